/* File: pkg/ccp_pkg.sv */
// Shared register map, field layouts, reset values and modes for the capture/compare block.
package ccp_pkg;

	// --------------------------------------------------------------
	// Register indices (byte address is four times the index)
	// --------------------------------------------------------------
	localparam logic [7:0] IDX_INTERRUPT_CONTROL = 8'h0B;
	localparam logic [7:0] IDX_PERIPHERAL_IRQ_FLAGS = 8'h0C;
	localparam logic [7:0] IDX_COUNTER16_LOW_BYTE = 8'h0E;
	localparam logic [7:0] IDX_COUNTER16_HIGH_BYTE = 8'h0F;
	localparam logic [7:0] IDX_COUNTER16_CONTROL = 8'h10;
	localparam logic [7:0] IDX_COUNTER8_VALUE = 8'h11;
	localparam logic [7:0] IDX_COUNTER8_CONTROL = 8'h12;
	localparam logic [7:0] IDX_CAPTURE_VALUE_LOW = 8'h15;
	localparam logic [7:0] IDX_CAPTURE_VALUE_HIGH = 8'h16;
	localparam logic [7:0] IDX_CAPTURE_COMPARE_CONTROL = 8'h17;
	localparam logic [7:0] IDX_PERIPHERAL_IRQ_ENABLES = 8'h8C;
	localparam logic [7:0] IDX_COUNTER8_PERIOD = 8'h92;

	// --------------------------------------------------------------
	// Field positions and masks
	// --------------------------------------------------------------
	localparam int FLAG_COUNTER16_OVERFLOW = 0;
	localparam int FLAG_COUNTER8_MATCH = 1;
	localparam int FLAG_CAPTURE_COMPARE = 2;
	localparam logic [7:0] IRQ_WRITABLE_MASK = 8'h4F;
	localparam logic [7:0] CCP_CONTROL_MASK = 8'h3F;

	// --------------------------------------------------------------
	// Reset values
	// --------------------------------------------------------------
	localparam logic [7:0] RST_ZERO_BYTE = 8'h00;
	localparam logic [7:0] RST_COUNTER8_PERIOD = 8'hFF;

	// --------------------------------------------------------------
	// Control layouts
	// --------------------------------------------------------------
	typedef struct packed {
		logic [1:0] unused;
		logic [1:0] prescale_select;
		logic osc_enable;
		logic sync_n;
		logic clock_select;
		logic on;
	} ccp_counter16_control_t;

	typedef struct packed {
		logic unused;
		logic [3:0] counter8_postscale_select;
		logic counter8_on;
		logic [1:0] counter8_prescale_select;
	} ccp_counter8_control_t;

	typedef enum logic [3:0] {
		CCP_MODE_OFF = 4'h0,
		CCP_MODE_CAP_FALL = 4'h4,
		CCP_MODE_CAP_RISE = 4'h5,
		CCP_MODE_CAP_RISE4 = 4'h6,
		CCP_MODE_CAP_RISE16 = 4'h7,
		CCP_MODE_CMP_SET = 4'h8,
		CCP_MODE_CMP_CLEAR = 4'h9,
		CCP_MODE_CMP_SOFT = 4'hA,
		CCP_MODE_CMP_EVENT = 4'hB
	} ccp_mode_t;

endpackage

/* File: design/ccp_capture_timebases.sv */
// Capture/compare unit with its 16-bit and 8-bit time-bases behind a Wishbone slave.
//
// The Wishbone register port was decided locally.
`timescale 1ns/1ps
// Notes on behaviour
// - Special event compare match clears the 16-bit timer and requests converter start.
// - The special event clear never sets the 16-bit overflow flag.
// - A software write to the 16-bit timer beats a simultaneous special event clear.
// - The 16-bit timer bytes survive every reset; only the special event clears them.
// - The 16-bit control register zeroes on power-on or brown-out reset only.
// - Writing either 16-bit timer byte clears its prescaler counter.
// - The 8-bit counter is read/write and zeroed by any reset.
// - The 8-bit prescale field selects divide by 1, 4 or 16.
// - The 8-bit counter counts up to the period value, then wraps to zero.
// - The period register is read/write and resets to all ones.
// - Period matches pass a 1 to 16 postscaler whose terminal count sets the flag.
// - The 8-bit counter only counts while its on bit is set.
// - Counter or control writes and resets clear 8-bit pre/postscalers; control writes keep the counter.
// - The pre-postscaler period match pulse is offered to the serial port.
// - A capture event copies the 16-bit timer and sets the capture/compare flag.
// - Only software or a reset clears the flag; later captures overwrite the held value.
// - Edges are detected on the pin level itself, whoever drives it.
// - Capture prescaler clears when off, outside capture modes, or on reset.
// - In timer mode the 16-bit timer increments once per 1, 2, 4 or 8 instruction cycles, by its prescale select.
// - In set and clear compare modes a match drives the pin action and sets the flag together.
module ccp_capture_timebases (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic por_i,
	input wire logic ce_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [31:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	input wire logic ccp_pin_i,
	input wire logic t1_clk_i,
	input wire logic adc_enabled_i,
	output logic ccp_out_o,
	output logic ad_start_o,
	output logic period_match_o
);

	// --------------------------------------------------------------
	// State
	// --------------------------------------------------------------
	logic [7:0] interrupt_control;
	logic [7:0] peripheral_irq_flags;
	logic [7:0] peripheral_irq_enables;
	logic [15:0] counter16;
	ccp_pkg::ccp_counter16_control_t counter16_control;
	logic [2:0] pre16;
	logic [7:0] counter8_value;
	ccp_pkg::ccp_counter8_control_t counter8_control;
	logic [7:0] counter8_period;
	logic [3:0] pre8;
	logic [3:0] post8;
	logic [15:0] capture_value;
	logic [5:0] capture_compare_control;
	logic [3:0] cap_pre;
	logic pin_meta, pin_sync, pin_prev;
	logic t1_meta, t1_sync, t1_prev;

	// --------------------------------------------------------------
	// Bus decode
	// --------------------------------------------------------------
	wire any_rst = rst_i | por_i;
	wire [7:0] idx = adr_i[9:2];
	wire req = cyc_i & stb_i & ~ack_o & ce_i;
	wire wr = req & we_i & sel_i[0] & (adr_i[31:10] == 22'h0);
	wire [7:0] wd = dat_i[7:0];
	wire wr_intc = wr & (idx == ccp_pkg::IDX_INTERRUPT_CONTROL);
	wire wr_flags = wr & (idx == ccp_pkg::IDX_PERIPHERAL_IRQ_FLAGS);
	wire wr_en = wr & (idx == ccp_pkg::IDX_PERIPHERAL_IRQ_ENABLES);
	wire wr_t1l = wr & (idx == ccp_pkg::IDX_COUNTER16_LOW_BYTE);
	wire wr_t1h = wr & (idx == ccp_pkg::IDX_COUNTER16_HIGH_BYTE);
	wire wr_counter16_control = wr & (idx == ccp_pkg::IDX_COUNTER16_CONTROL);
	wire wr_t2 = wr & (idx == ccp_pkg::IDX_COUNTER8_VALUE);
	wire wr_counter8_control = wr & (idx == ccp_pkg::IDX_COUNTER8_CONTROL);
	wire wr_pr2 = wr & (idx == ccp_pkg::IDX_COUNTER8_PERIOD);
	wire wr_capl = wr & (idx == ccp_pkg::IDX_CAPTURE_VALUE_LOW);
	wire wr_caph = wr & (idx == ccp_pkg::IDX_CAPTURE_VALUE_HIGH);
	wire wr_ccpcon = wr & (idx == ccp_pkg::IDX_CAPTURE_COMPARE_CONTROL);

	logic [7:0] rd_mux;
	always_comb begin
		rd_mux = 8'h00;
		if (adr_i[31:10] == 22'h0) begin
			unique case (idx)
				ccp_pkg::IDX_INTERRUPT_CONTROL: rd_mux = interrupt_control;
				ccp_pkg::IDX_PERIPHERAL_IRQ_FLAGS: rd_mux = peripheral_irq_flags;
				ccp_pkg::IDX_PERIPHERAL_IRQ_ENABLES: rd_mux = peripheral_irq_enables;
				ccp_pkg::IDX_COUNTER16_LOW_BYTE: rd_mux = counter16[7:0];
				ccp_pkg::IDX_COUNTER16_HIGH_BYTE: rd_mux = counter16[15:8];
				ccp_pkg::IDX_COUNTER16_CONTROL: rd_mux = counter16_control;
				ccp_pkg::IDX_COUNTER8_VALUE: rd_mux = counter8_value;
				ccp_pkg::IDX_COUNTER8_CONTROL: rd_mux = counter8_control;
				ccp_pkg::IDX_COUNTER8_PERIOD: rd_mux = counter8_period;
				ccp_pkg::IDX_CAPTURE_VALUE_LOW: rd_mux = capture_value[7:0];
				ccp_pkg::IDX_CAPTURE_VALUE_HIGH: rd_mux = capture_value[15:8];
				ccp_pkg::IDX_CAPTURE_COMPARE_CONTROL: rd_mux = {2'b00, capture_compare_control};
				default: rd_mux = 8'h00;
			endcase
		end
	end

	// Unmapped addresses still acknowledge and read as zero, so the bus never hangs.
	always_ff @(posedge clk_i) begin
		if (any_rst) begin
			ack_o <= 1'b0;
			dat_o <= 32'h0000_0000;
		end else if (ce_i) begin
			ack_o <= cyc_i & stb_i & ~ack_o;
			if (req) begin
				dat_o <= {24'h00_0000, rd_mux};
			end
		end
	end

	// --------------------------------------------------------------
	// Pin synchronisers and edges
	// --------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (ce_i) begin
			pin_meta <= ccp_pin_i;
			pin_sync <= pin_meta;
			pin_prev <= pin_sync;
			t1_meta <= t1_clk_i;
			t1_sync <= t1_meta;
			t1_prev <= t1_sync;
		end
	end

	wire pin_rise = pin_sync & ~pin_prev;
	wire pin_fall = ~pin_sync & pin_prev;
	wire t1_rise = t1_sync & ~t1_prev;

	// --------------------------------------------------------------
	// Capture/compare decode
	// --------------------------------------------------------------
	wire [3:0] mode = capture_compare_control[3:0];
	wire is_capture = (mode[3:2] == 2'b01);
	wire is_compare = (mode[3:2] == 2'b10);
	wire cap_edge = (mode == ccp_pkg::CCP_MODE_CAP_FALL) ? pin_fall : pin_rise;
	wire cap_evt = is_capture & cap_edge & (
		(mode == ccp_pkg::CCP_MODE_CAP_FALL) ||
		(mode == ccp_pkg::CCP_MODE_CAP_RISE) ||
		(mode == ccp_pkg::CCP_MODE_CAP_RISE4 && cap_pre[1:0] == 2'b11) ||
		(mode == ccp_pkg::CCP_MODE_CAP_RISE16 && cap_pre == 4'hF));
	wire cmp_match = is_compare & (counter16 == capture_value);
	wire sev = cmp_match & (mode == ccp_pkg::CCP_MODE_CMP_EVENT);

	// Switching directly between capture prescales keeps the count, so the first
	// capture after such a switch may come early; software zeroes the mode first.
	always_ff @(posedge clk_i) begin
		if (any_rst) begin
			cap_pre <= 4'h0;
		end else if (ce_i) begin
			if (!is_capture) begin
				cap_pre <= 4'h0;
			end else if (pin_rise && mode[1]) begin
				cap_pre <= cap_pre + 4'h1;
			end
		end
	end

	// --------------------------------------------------------------
	// 16-bit timer
	// --------------------------------------------------------------
	wire [3:0] pre16_lim = (4'h1 << counter16_control.prescale_select) - 4'h1;
	wire src16 = counter16_control.clock_select ? t1_rise : 1'b1;
	wire pre16_hit = ({1'b0, pre16} == pre16_lim);
	wire inc16 = counter16_control.on & src16 & pre16_hit;
	wire wr16 = wr_t1l | wr_t1h;
	wire ovf_set = inc16 & (counter16 == 16'hFFFF) & ~sev & ~wr16;

	// Asynchronous counting is not modelled apart: external edges are always
	// sampled, which is what capture and special event need anyway.
	always_ff @(posedge clk_i) begin
		if (ce_i) begin
			if (wr16) begin
				if (wr_t1l) begin
					counter16[7:0] <= wd;
				end
				if (wr_t1h) begin
					counter16[15:8] <= wd;
				end
			end else if (sev) begin
				counter16 <= 16'h0000;
			end else if (inc16) begin
				counter16 <= counter16 + 16'h0001;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (any_rst) begin
			pre16 <= 3'h0;
		end else if (ce_i) begin
			if (wr16) begin
				pre16 <= 3'h0;
			end else if (counter16_control.on && src16) begin
				pre16 <= pre16_hit ? 3'h0 : pre16 + 3'h1;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (por_i) begin
			counter16_control <= ccp_pkg::RST_ZERO_BYTE;
		end else if (ce_i && wr_counter16_control) begin
			counter16_control <= {2'b00, wd[5:0]};
		end
	end

	// --------------------------------------------------------------
	// 8-bit timer
	// --------------------------------------------------------------
	wire [1:0] ps8 = counter8_control.counter8_prescale_select;
	wire pre8_hit = (ps8 == 2'b00) || (ps8 == 2'b01 && pre8[1:0] == 2'b11) ||
		(ps8[1] && pre8 == 4'hF);
	wire clr8 = wr_t2 | wr_counter8_control;
	wire tick8 = counter8_control.counter8_on & pre8_hit & ~clr8;
	wire match8 = tick8 & (counter8_value == counter8_period);
	wire post_hit = match8 & (post8 == counter8_control.counter8_postscale_select);

	always_ff @(posedge clk_i) begin
		if (any_rst) begin
			counter8_value <= ccp_pkg::RST_ZERO_BYTE;
			counter8_control <= ccp_pkg::RST_ZERO_BYTE;
			counter8_period <= ccp_pkg::RST_COUNTER8_PERIOD;
			pre8 <= 4'h0;
			post8 <= 4'h0;
			period_match_o <= 1'b0;
		end else if (ce_i) begin
			period_match_o <= match8;
			if (wr_t2) begin
				counter8_value <= wd;
			end else if (match8) begin
				counter8_value <= 8'h00;
			end else if (tick8) begin
				counter8_value <= counter8_value + 8'h01;
			end
			if (wr_counter8_control) begin
				counter8_control <= {1'b0, wd[6:0]};
			end
			if (wr_pr2) begin
				counter8_period <= wd;
			end
			if (clr8) begin
				pre8 <= 4'h0;
				post8 <= 4'h0;
			end else begin
				if (counter8_control.counter8_on) begin
					pre8 <= pre8_hit ? 4'h0 : pre8 + 4'h1;
				end
				if (match8) begin
					post8 <= post_hit ? 4'h0 : post8 + 4'h1;
				end
			end
		end
	end

	// --------------------------------------------------------------
	// Capture register, compare output, converter start
	// --------------------------------------------------------------
	// A capture on the same edge as a software write to the pair wins.
	always_ff @(posedge clk_i) begin
		if (ce_i) begin
			if (cap_evt) begin
				capture_value <= counter16;
			end else begin
				if (wr_capl) begin
					capture_value[7:0] <= wd;
				end
				if (wr_caph) begin
					capture_value[15:8] <= wd;
				end
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (any_rst) begin
			capture_compare_control <= 6'h00;
			ccp_out_o <= 1'b0;
			ad_start_o <= 1'b0;
		end else if (ce_i) begin
			if (wr_ccpcon) begin
				capture_compare_control <= wd[5:0] & ccp_pkg::CCP_CONTROL_MASK[5:0];
			end
			ad_start_o <= sev & adc_enabled_i;
			if (mode == ccp_pkg::CCP_MODE_OFF) begin
				ccp_out_o <= 1'b0;
			end else if (cmp_match && mode == ccp_pkg::CCP_MODE_CMP_SET) begin
				ccp_out_o <= 1'b1;
			end else if (cmp_match && mode == ccp_pkg::CCP_MODE_CMP_CLEAR) begin
				ccp_out_o <= 1'b0;
			end
		end
	end

	// --------------------------------------------------------------
	// Flags and enables
	// --------------------------------------------------------------
	// Hardware sets win over a software clear in the same cycle.
	wire [7:0] flag_set = ({7'h00, ovf_set} << ccp_pkg::FLAG_COUNTER16_OVERFLOW) |
		({7'h00, post_hit} << ccp_pkg::FLAG_COUNTER8_MATCH) |
		({7'h00, cap_evt | cmp_match} << ccp_pkg::FLAG_CAPTURE_COMPARE);
	wire [7:0] flag_keep = wr_flags ? (wd & ccp_pkg::IRQ_WRITABLE_MASK) : peripheral_irq_flags;

	always_ff @(posedge clk_i) begin
		if (any_rst) begin
			peripheral_irq_flags <= ccp_pkg::RST_ZERO_BYTE;
			peripheral_irq_enables <= ccp_pkg::RST_ZERO_BYTE;
			interrupt_control <= ccp_pkg::RST_ZERO_BYTE;
		end else if (ce_i) begin
			peripheral_irq_flags <= flag_keep | flag_set;
			if (wr_en) begin
				peripheral_irq_enables <= wd & ccp_pkg::IRQ_WRITABLE_MASK;
			end
			if (wr_intc) begin
				interrupt_control <= wd;
			end
		end
	end

	// --------------------------------------------------------------
	// Assertions
	// --------------------------------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (any_rst);

	a_sev_clears_t16: assert property (ce_i && sev && !wr16 |=> counter16 == 16'h0000)
		else $error("special event did not clear the 16-bit timer");
	a_sev_no_ovf: assert property (ce_i && sev && !peripheral_irq_flags[0] && !wr_flags
		|=> !peripheral_irq_flags[0])
		else $error("special event set the overflow flag");
	a_write_beats_sev: assert property (ce_i && sev && wr_t1l
		|=> counter16[7:0] == $past(dat_i[7:0]))
		else $error("timer write lost against special event");
	a_t16_pre_clear: assert property (ce_i && wr16 |=> pre16 == 3'h0)
		else $error("timer write left prescaler running");
	a_t8_wraps: assert property (ce_i && tick8 && counter8_value == counter8_period && !wr_t2
		|=> counter8_value == 8'h00 && period_match_o)
		else $error("8-bit timer did not wrap at period");
	a_t8_halted: assert property (ce_i && !counter8_control.counter8_on && !wr_t2
		|=> $stable(counter8_value))
		else $error("8-bit timer counted while off");
	a_t8con_keeps: assert property (ce_i && wr_counter8_control && !wr_t2
		|=> pre8 == 4'h0 && post8 == 4'h0 && $stable(counter8_value))
		else $error("control write mishandled 8-bit counters");
	a_post_sets_flag: assert property (ce_i && post_hit |=> peripheral_irq_flags[1])
		else $error("postscaler terminal count lost");
	a_capture_copies: assert property (ce_i && cap_evt
		|=> capture_value == $past(counter16) && peripheral_irq_flags[2])
		else $error("capture did not copy timer or set flag");
	a_cap_pre_clear: assert property (ce_i && !is_capture |=> cap_pre == 4'h0)
		else $error("capture prescaler not cleared");

endmodule

/* File: bench/ccp_pin_model.sv */
// Behavioural source of pulse trains on the capture pin.
`timescale 1ns/1ps
module ccp_pin_model (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic req_i,
	input wire logic [5:0] count_i,
	output logic pin_o,
	output logic busy_o
);
	logic [5:0] left;
	logic [2:0] phase;

	// Four cycles high and four low per pulse, so that a two-stage synchronizer sees every edge.
	assign busy_o = (left != 6'h00);
	assign pin_o = busy_o && !phase[2];

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			left <= 6'h00;
			phase <= 3'h0;
		end else if (!busy_o) begin
			left <= req_i ? count_i : 6'h00;
			phase <= 3'h0;
		end else begin
			phase <= phase + 3'h1;
			if (phase == 3'h7) begin
				left <= left - 6'h01;
			end
		end
	end
endmodule

/* File: bench/tb_top.sv */
// Self-checking bench for the capture/compare block and its two time-bases.
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin n_compared++; if ((got) !== (exp)) begin miscompares++; \
	$display("FAIL %s expected %0h seen %0h", nm, exp, got); end end
module tb_top;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic por_i = 1'b1;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic we = 1'b0;
	logic [31:0] adr = 32'h0;
	logic [31:0] dat = 32'h0;
	logic [31:0] dat_o;
	logic ack_o, ccp_pin, ccp_out_o, ad_start_o, period_match_o, busy;
	logic req = 1'b0;
	logic adc_en = 1'b0;
	logic [5:0] cnt = 6'h00;
	logic [7:0] q;
	int miscompares = 0;
	int n_compared = 0;

	always #4 clk_i = ~clk_i;

	ccp_capture_timebases u_ccp_capture_timebases (.clk_i(clk_i), .rst_i(rst_i), .por_i(por_i),
		.ce_i(1'b1), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(4'h1), .dat_i(dat),
		.dat_o(dat_o), .ack_o(ack_o), .ccp_pin_i(ccp_pin), .t1_clk_i(1'b0), .adc_enabled_i(adc_en),
		.ccp_out_o(ccp_out_o), .ad_start_o(ad_start_o), .period_match_o(period_match_o));
	ccp_pin_model u_ccp_pin_model (.clk_i(clk_i), .rst_i(rst_i), .req_i(req), .count_i(cnt),
		.pin_o(ccp_pin), .busy_o(busy));

	// ------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------
	task automatic wrap_up();
		$display("compared %0d miscompares %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	task automatic expire();
		miscompares++;
		$display("FAIL wait limit expected 1 seen 0");
		wrap_up();
	endtask

	// One classic Wishbone cycle; the read byte is left in q.
	task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] d);
		int n;
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= {22'h0, idx, 2'h0};
		dat <= {24'h0, d};
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack_o !== 1'b1 && n < 20);
		q = dat_o[7:0];
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
		if (n >= 20) begin
			expire();
		end
	endtask

	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		bus(1'b1, idx, d);
	endtask

	task automatic rd(input logic [7:0] idx);
		bus(1'b0, idx, 8'h00);
	endtask

	// Pin edges act after synchronizing, so eight idle cycles follow each train.
	task automatic fire(input logic [5:0] n);
		int k;
		if (n != 6'h00) begin
			@(posedge clk_i);
			req <= 1'b1;
			cnt <= n;
			@(posedge clk_i);
			req <= 1'b0;
			k = 0;
			do begin
				@(posedge clk_i);
				k++;
			end while (busy === 1'b1 && k < 400);
			if (k >= 400) begin
				expire();
			end
		end
		repeat (8) @(posedge clk_i);
	endtask

	task automatic count_pulses(input int n, input logic which, output int c);
		c = 0;
		repeat (n) begin
			@(posedge clk_i);
			if ((which ? ad_start_o : period_match_o) === 1'b1) begin
				c++;
			end
		end
	endtask

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic check_reset_values();
		logic [7:0] ix [8] = '{ccp_pkg::IDX_PERIPHERAL_IRQ_FLAGS, ccp_pkg::IDX_PERIPHERAL_IRQ_ENABLES,
			ccp_pkg::IDX_INTERRUPT_CONTROL, ccp_pkg::IDX_COUNTER8_VALUE, ccp_pkg::IDX_COUNTER8_CONTROL,
			ccp_pkg::IDX_COUNTER8_PERIOD, ccp_pkg::IDX_CAPTURE_COMPARE_CONTROL, 8'h40};
		logic [7:0] ex [8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hFF, 8'h00, 8'h00};
		for (int i = 0; i < 8; i++) begin
			rd(ix[i]);
			`CHK("reset value", ex[i], q)
		end
	endtask

	task automatic counter8_scalers();
		int c;
		int ex [4] = '{32, 8, 2, 2};
		wr(ccp_pkg::IDX_COUNTER8_PERIOD, 8'h03);
		for (int p = 0; p < 4; p++) begin
			wr(ccp_pkg::IDX_COUNTER8_CONTROL, 8'h04 | 8'(p));
			wr(ccp_pkg::IDX_COUNTER8_VALUE, 8'h00);
			count_pulses(128, 1'b0, c);
			`CHK("period matches", ex[p], c)
		end
		wr(ccp_pkg::IDX_COUNTER8_CONTROL, 8'h00);
		wr(ccp_pkg::IDX_COUNTER8_VALUE, 8'h02);
		wr(ccp_pkg::IDX_COUNTER8_CONTROL, 8'h78);
		repeat (20) @(posedge clk_i);
		rd(ccp_pkg::IDX_COUNTER8_VALUE);
		`CHK("counter8 held", 8'h02, q)
		wr(ccp_pkg::IDX_PERIPHERAL_IRQ_FLAGS, 8'h00);
		wr(ccp_pkg::IDX_COUNTER8_CONTROL, 8'h7C);
		wr(ccp_pkg::IDX_COUNTER8_VALUE, 8'h00);
		repeat (40) @(posedge clk_i);
		rd(ccp_pkg::IDX_PERIPHERAL_IRQ_FLAGS);
		`CHK("match flag early", 1'b0, q[1])
		repeat (40) @(posedge clk_i);
		rd(ccp_pkg::IDX_PERIPHERAL_IRQ_FLAGS);
		`CHK("match flag", 1'b1, q[1])
		wr(ccp_pkg::IDX_COUNTER8_CONTROL, 8'h00);
	endtask

	task automatic capture_modes();
		logic [3:0] m [4] = '{4'h4, 4'h5, 4'h6, 4'h7};
		logic [5:0] n [4] = '{6'h01, 6'h01, 6'h04, 6'h10};
		logic [7:0] c1;
		wr(ccp_pkg::IDX_COUNTER16_CONTROL, 8'h31);
		for (int i = 0; i < 4; i++) begin
			wr(ccp_pkg::IDX_CAPTURE_COMPARE_CONTROL, 8'h00);
			wr(ccp_pkg::IDX_CAPTURE_COMPARE_CONTROL, {4'h0, m[i]});
			wr(ccp_pkg::IDX_COUNTER16_HIGH_BYTE, 8'h00);
			wr(ccp_pkg::IDX_COUNTER16_LOW_BYTE, 8'h00);
			wr(ccp_pkg::IDX_PERIPHERAL_IRQ_FLAGS, 8'h00);
			fire(n[i] - 6'h01);
			rd(ccp_pkg::IDX_PERIPHERAL_IRQ_FLAGS);
			`CHK("capture flag early", 1'b0, q[2])
			fire(6'h01);
			rd(ccp_pkg::IDX_PERIPHERAL_IRQ_FLAGS);
			`CHK("capture flag", 1'b1, q[2])
			rd(ccp_pkg::IDX_CAPTURE_VALUE_HIGH);
			`CHK("capture high", 8'h00, q)
			rd(ccp_pkg::IDX_CAPTURE_VALUE_LOW);
			c1 = q;
			rd(ccp_pkg::IDX_COUNTER16_LOW_BYTE);
			`CHK("capture bound", 1'b1, c1 <= q)
			fire(n[i]);
			rd(ccp_pkg::IDX_CAPTURE_VALUE_LOW);
			`CHK("capture overwrite", 1'b1, q > c1)
		end
	endtask

	task automatic compare_modes();
		int c;
		wr(ccp_pkg::IDX_COUNTER16_CONTROL, 8'h01);
		wr(ccp_pkg::IDX_CAPTURE_VALUE_LOW, 8'h40);
		wr(ccp_pkg::IDX_CAPTURE_VALUE_HIGH, 8'h00);
		for (int s = 0; s < 3; s++) begin
			wr(ccp_pkg::IDX_CAPTURE_COMPARE_CONTROL, 8'h08 + 8'(s));
			wr(ccp_pkg::IDX_PERIPHERAL_IRQ_FLAGS, 8'h00);
			wr(ccp_pkg::IDX_COUNTER16_HIGH_BYTE, 8'h00);
			wr(ccp_pkg::IDX_COUNTER16_LOW_BYTE, 8'h00);
			repeat (100) @(posedge clk_i);
			`CHK("compare output", s == 0, ccp_out_o)
			rd(ccp_pkg::IDX_PERIPHERAL_IRQ_FLAGS);
			`CHK("compare flag", 1'b1, q[2])
		end
		wr(ccp_pkg::IDX_CAPTURE_COMPARE_CONTROL, 8'h0B);
		// The timer is already past the compare value here, so it restarts from zero.
		wr(ccp_pkg::IDX_COUNTER16_HIGH_BYTE, 8'h00);
		wr(ccp_pkg::IDX_COUNTER16_LOW_BYTE, 8'h00);
		@(posedge clk_i);
		adc_en <= 1'b1;
		count_pulses(260, 1'b1, c);
		`CHK("converter starts", 4, c)
		rd(ccp_pkg::IDX_COUNTER16_LOW_BYTE);
		`CHK("counter16 bounded", 1'b1, q <= 8'h40)
		rd(ccp_pkg::IDX_PERIPHERAL_IRQ_FLAGS);
		`CHK("overflow flag", 1'b0, q[0])
		adc_en <= 1'b0;
		count_pulses(130, 1'b1, c);
		`CHK("converter idle", 0, c)
		// A match at the top count must clear the timer without raising the overflow flag.
		wr(ccp_pkg::IDX_CAPTURE_VALUE_HIGH, 8'hFF);
		wr(ccp_pkg::IDX_CAPTURE_VALUE_LOW, 8'hFF);
		wr(ccp_pkg::IDX_COUNTER16_HIGH_BYTE, 8'hFF);
		wr(ccp_pkg::IDX_COUNTER16_LOW_BYTE, 8'hF0);
		wr(ccp_pkg::IDX_PERIPHERAL_IRQ_FLAGS, 8'h00);
		repeat (20) @(posedge clk_i);
		rd(ccp_pkg::IDX_PERIPHERAL_IRQ_FLAGS);
		`CHK("overflow flag at top", 1'b0, q[0])
		rd(ccp_pkg::IDX_COUNTER16_HIGH_BYTE);
		`CHK("counter16 cleared at top", 8'h00, q)
		wr(ccp_pkg::IDX_CAPTURE_COMPARE_CONTROL, 8'h00);
	endtask

	task automatic reset_keep();
		wr(ccp_pkg::IDX_COUNTER16_CONTROL, 8'h00);
		wr(ccp_pkg::IDX_COUNTER16_LOW_BYTE, 8'h5A);
		wr(ccp_pkg::IDX_COUNTER16_HIGH_BYTE, 8'hA5);
		wr(ccp_pkg::IDX_COUNTER16_CONTROL, 8'h30);
		wr(ccp_pkg::IDX_COUNTER8_VALUE, 8'h07);
		@(posedge clk_i);
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		check_reset_values();
		rd(ccp_pkg::IDX_COUNTER16_CONTROL);
		`CHK("counter16 control kept", 8'h30, q)
		rd(ccp_pkg::IDX_COUNTER16_HIGH_BYTE);
		`CHK("counter16 high kept", 8'hA5, q)
		@(posedge clk_i);
		por_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		por_i <= 1'b0;
		rd(ccp_pkg::IDX_COUNTER16_CONTROL);
		`CHK("counter16 control cleared", 8'h00, q)
		rd(ccp_pkg::IDX_COUNTER16_LOW_BYTE);
		`CHK("counter16 low kept", 8'h5A, q)
	endtask

	initial begin
		repeat (20) @(posedge clk_i);
		rst_i <= 1'b0;
		por_i <= 1'b0;
		check_reset_values();
		rd(ccp_pkg::IDX_COUNTER16_CONTROL);
		`CHK("counter16 control", 8'h00, q)
		counter8_scalers();
		capture_modes();
		compare_modes();
		reset_keep();
		wrap_up();
	end
endmodule
